// >>> plcs_pkg.sv
package plcs_pkg;
   // Combined dword holding control (15:0) and status (31:16)
   localparam logic [11:0] LINK_CTRL_STAT_OFFSET = 12'h0d0;

   // Control field positions
   localparam int ASPM_LSB        = 0;
   localparam int RCB_BIT         = 3;
   localparam int LINK_DIS_BIT    = 4;
   localparam int RETRAIN_BIT     = 5;
   localparam int COMMON_CLK_BIT  = 6;
   localparam int EXT_SYNC_BIT    = 7;
   localparam int HW_AUTO_WD_BIT  = 9;
   localparam int BW_MGMT_IE_BIT  = 10;
   localparam int AUTO_BW_IE_BIT  = 11;

   // Status field positions
   localparam int SPEED_LSB       = 16;
   localparam int WIDTH_LSB       = 20;
   localparam int TRAIN_ERR_BIT   = 26;
   localparam int TRAINING_BIT    = 27;
   localparam int SLOT_CLK_BIT    = 28;
   localparam int DL_ACTIVE_BIT   = 29;

   // Reset values
   localparam logic [1:0] ASPM_RST   = 2'h0;
   localparam logic [3:0] SPEED_RST  = 4'h2;
   localparam logic [5:0] WIDTH_RST  = 6'h01;

   // Power-management control codes
   localparam logic [1:0] ASPM_NONE  = 2'h0;
   localparam logic [1:0] ASPM_L0S   = 2'h1;
   localparam logic [1:0] ASPM_L1    = 2'h2;
   localparam logic [1:0] ASPM_BOTH  = 2'h3;

   // Speed codes
   localparam logic [3:0] SPEED_2G5  = 4'h1;
   localparam logic [3:0] SPEED_5G0  = 4'h2;

   // Extended synchronisation ordered-set counts
   localparam logic [12:0] FTS_EXT_CNT = 13'h1000;
   localparam logic [12:0] TS1_EXT_CNT = 13'h0400;
endpackage

// >>> plcs_link_regs.sv
// Functional notes
// [R01] ASPM field: 00 none, 01 L0s, 10 L1, 11 both; resets to 00.
// [R02] Receive side may enter L0s even with ASPM disabled.
// [R03] Completion boundary bit always reads zero.
// [R04] Link disable takes link down on downstream; fixed zero upstream; resets zero.
// [R05] Retrain write-one starts retraining on downstream; fixed zero upstream.
// [R06] Retrain bit always reads zero.
// [R07] Common-clock bit is read-write storage, resets zero.
// [R08] Extended sync: 4096 FTS leaving L0s, 1024 TS1 leaving L1.
// [R09] Autonomous width disable at bit 9 is read-write, resets zero.
// [R10] Bandwidth interrupt enables read-only upstream, read-write downstream; reset zero.
// [R11] Speed field reports 0001 for 2.5G, 0010 for 5G; resets 0010.
// [R12] Width field 25:20 reports trained lanes; resets to x1.
// [R13] Training error set on failure, cleared on successful L0 entry.
// [R14] Training bit set during training, cleared on completion; resets zero.
// [R15] Slot clock bit taken from strap at reset, overridable by loader.
// [R16] Data-link-active bit is one only in active state.
// [R17] Reserved bits read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module plcs_link_regs
   import plcs_pkg::*;
#(
   parameter bit UPSTREAM = 1'b0
) (
   input  wire logic        MCLK_I,
   input  wire logic        SYS_RST_I,
   // Configuration access to the combined dword
   input  wire logic        CFG_WR_I,
   input  wire logic        CFG_RD_I,
   input  wire logic [11:0] CFG_ADDR_I,
   input  wire logic [3:0]  CFG_BE_I,
   input  wire logic [31:0] CFG_WDATA_I,
   output logic      [31:0] CFG_RDATA_O,
   output logic             CFG_HIT_O,
   // From link training and data link logic
   input  wire logic        TRAIN_START_I,
   input  wire logic        TRAIN_FAIL_I,
   input  wire logic        TRAIN_DONE_I,
   input  wire logic [3:0]  LINK_SPEED_I,
   input  wire logic [5:0]  LINK_WIDTH_I,
   input  wire logic        DL_ACTIVE_I,
   input  wire logic        SLOT_CLOCK_STRAP_I,
   input  wire logic        LOADER_SLOT_CLK_WR_I,
   input  wire logic        LOADER_SLOT_CLK_I,
   // To link training logic
   output logic             L0S_TX_EN_O,
   output logic             L1_EN_O,
   output logic             L0S_RX_EN_O,
   output logic             LINK_DISABLE_O,
   output logic             RETRAIN_O,
   output logic             COMMON_CLK_O,
   output logic [12:0]      FTS_COUNT_O,
   output logic [12:0]      TS1_COUNT_O,
   output logic             HW_AUTO_WIDTH_DIS_O,
   output logic             BW_MGMT_IE_O,
   output logic             AUTO_BW_IE_O
);
   import plcs_pkg::*;

   logic [1:0]  aspm_q, aspm_d;
   logic        link_dis_q, link_dis_d;
   logic        retrain_q, retrain_d;
   logic        common_clk_q, common_clk_d;
   logic        ext_sync_q, ext_sync_d;
   logic        hw_auto_wd_q, hw_auto_wd_d;
   logic        bw_mgmt_ie_q, bw_mgmt_ie_d;
   logic        auto_bw_ie_q, auto_bw_ie_d;
   logic [3:0]  speed_q, speed_d;
   logic [5:0]  width_q, width_d;
   logic        train_err_q, train_err_d;
   logic        training_q, training_d;
   logic        slot_clk_q, slot_clk_d;
   logic        strap_taken_q, strap_taken_d;
   logic        dl_active_q, dl_active_d;
   logic [31:0] rdata_q, rdata_d;
   logic        hit_q, hit_d;

   logic        addr_hit;
   logic        wr_lo;
   logic        wr_hi;

   always_comb begin
      addr_hit = (CFG_ADDR_I == LINK_CTRL_STAT_OFFSET);
      wr_lo    = CFG_WR_I && addr_hit && CFG_BE_I[0];
      wr_hi    = CFG_WR_I && addr_hit && CFG_BE_I[1];

      aspm_d       = aspm_q;
      link_dis_d   = link_dis_q;
      common_clk_d = common_clk_q;
      ext_sync_d   = ext_sync_q;
      hw_auto_wd_d = hw_auto_wd_q;
      bw_mgmt_ie_d = bw_mgmt_ie_q;
      auto_bw_ie_d = auto_bw_ie_q;
      retrain_d    = 1'b0;

      if (wr_lo) begin
         aspm_d       = CFG_WDATA_I[ASPM_LSB +: 2]; // [R01]
         common_clk_d = CFG_WDATA_I[COMMON_CLK_BIT]; // [R07]
         ext_sync_d   = CFG_WDATA_I[EXT_SYNC_BIT];
         if (!UPSTREAM) begin
            link_dis_d = CFG_WDATA_I[LINK_DIS_BIT]; // [R04]
            retrain_d  = CFG_WDATA_I[RETRAIN_BIT]; // [R05]
         end
      end
      if (wr_hi) begin
         hw_auto_wd_d = CFG_WDATA_I[HW_AUTO_WD_BIT]; // [R09]
         if (!UPSTREAM) begin
            bw_mgmt_ie_d = CFG_WDATA_I[BW_MGMT_IE_BIT]; // [R10]
            auto_bw_ie_d = CFG_WDATA_I[AUTO_BW_IE_BIT]; // [R10]
         end
      end

      // Status tracks the training logic; the loader may override the strap
      speed_d     = ((LINK_SPEED_I == SPEED_2G5) || (LINK_SPEED_I == SPEED_5G0)) ?
                    LINK_SPEED_I : speed_q; // [R11]
      width_d     = TRAIN_DONE_I ? LINK_WIDTH_I : width_q; // [R12]
      // Fail wins over done when both arrive together
      train_err_d = TRAIN_FAIL_I ? 1'b1 : (TRAIN_DONE_I ? 1'b0 : train_err_q); // [R13]
      training_d  = TRAIN_START_I ? 1'b1 :
                    ((TRAIN_DONE_I || TRAIN_FAIL_I) ? 1'b0 : training_q); // [R14]
      dl_active_d = DL_ACTIVE_I; // [R16]
      strap_taken_d = 1'b1;
      slot_clk_d  = slot_clk_q;
      if (!strap_taken_q) begin
         slot_clk_d = SLOT_CLOCK_STRAP_I; // [R15]
      end else if (LOADER_SLOT_CLK_WR_I) begin
         slot_clk_d = LOADER_SLOT_CLK_I; // [R15]
      end

      // Reserved, completion boundary and retrain read zero
      rdata_d = 32'h0000_0000; // [R17]
      if (CFG_RD_I && addr_hit) begin
         rdata_d[ASPM_LSB +: 2]    = aspm_q;
         rdata_d[RCB_BIT]          = 1'b0; // [R03]
         rdata_d[LINK_DIS_BIT]     = link_dis_q;
         rdata_d[RETRAIN_BIT]      = 1'b0; // [R06]
         rdata_d[COMMON_CLK_BIT]   = common_clk_q;
         rdata_d[EXT_SYNC_BIT]     = ext_sync_q;
         rdata_d[HW_AUTO_WD_BIT]   = hw_auto_wd_q;
         rdata_d[BW_MGMT_IE_BIT]   = bw_mgmt_ie_q;
         rdata_d[AUTO_BW_IE_BIT]   = auto_bw_ie_q;
         rdata_d[SPEED_LSB +: 4]   = speed_q;
         rdata_d[WIDTH_LSB +: 6]   = width_q;
         rdata_d[TRAIN_ERR_BIT]    = train_err_q;
         rdata_d[TRAINING_BIT]     = training_q;
         rdata_d[SLOT_CLK_BIT]     = slot_clk_q;
         rdata_d[DL_ACTIVE_BIT]    = dl_active_q;
      end
      hit_d = (CFG_RD_I || CFG_WR_I) && addr_hit;
   end

   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         aspm_q        <= ASPM_RST;
         link_dis_q    <= 1'b0;
         retrain_q     <= 1'b0;
         common_clk_q  <= 1'b0;
         ext_sync_q    <= 1'b0;
         hw_auto_wd_q  <= 1'b0;
         bw_mgmt_ie_q  <= 1'b0;
         auto_bw_ie_q  <= 1'b0;
         speed_q       <= SPEED_RST;
         width_q       <= WIDTH_RST;
         train_err_q   <= 1'b0;
         training_q    <= 1'b0;
         slot_clk_q    <= 1'b0;
         strap_taken_q <= 1'b0;
         dl_active_q   <= 1'b0;
         rdata_q       <= 32'h0000_0000;
         hit_q         <= 1'b0;
      end else begin
         aspm_q        <= aspm_d;
         link_dis_q    <= link_dis_d;
         retrain_q     <= retrain_d;
         common_clk_q  <= common_clk_d;
         ext_sync_q    <= ext_sync_d;
         hw_auto_wd_q  <= hw_auto_wd_d;
         bw_mgmt_ie_q  <= bw_mgmt_ie_d;
         auto_bw_ie_q  <= auto_bw_ie_d;
         speed_q       <= speed_d;
         width_q       <= width_d;
         train_err_q   <= train_err_d;
         training_q    <= training_d;
         slot_clk_q    <= slot_clk_d;
         strap_taken_q <= strap_taken_d;
         dl_active_q   <= dl_active_d;
         rdata_q       <= rdata_d;
         hit_q         <= hit_d;
      end
   end

   // Control outputs, each a flop
   logic        l0s_tx_q, l1_q, link_down_q;
   logic [12:0] fts_q, ts1_q;

   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         l0s_tx_q    <= 1'b0;
         l1_q        <= 1'b0;
         link_down_q <= 1'b0;
         fts_q       <= 13'h0000;
         ts1_q       <= 13'h0000;
      end else begin
         l0s_tx_q    <= aspm_d[0]; // [R01]
         l1_q        <= aspm_d[1]; // [R01]
         link_down_q <= link_dis_d; // [R04]
         fts_q       <= ext_sync_d ? FTS_EXT_CNT : 13'h0000; // [R08]
         ts1_q       <= ext_sync_d ? TS1_EXT_CNT : 13'h0000; // [R08]
      end
   end
   assign CFG_RDATA_O         = rdata_q;
   assign CFG_HIT_O           = hit_q;
   assign L0S_TX_EN_O         = l0s_tx_q;
   assign L1_EN_O             = l1_q;
   // Receiver L0s never depends on the control field
   assign L0S_RX_EN_O         = strap_taken_q; // [R02]
   assign LINK_DISABLE_O      = link_down_q;
   assign RETRAIN_O           = retrain_q; // [R05]
   assign COMMON_CLK_O        = common_clk_q;
   assign FTS_COUNT_O         = fts_q;
   assign TS1_COUNT_O         = ts1_q;
   assign HW_AUTO_WIDTH_DIS_O = hw_auto_wd_q;
   assign BW_MGMT_IE_O        = bw_mgmt_ie_q;
   assign AUTO_BW_IE_O        = auto_bw_ie_q;
endmodule
`default_nettype wire

// >>> plcs_link_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module plcs_link_regs_chk #(
   parameter bit UPSTREAM = 1'b0
) (
   input wire logic        MCLK_I,
   input wire logic        SYS_RST_I,
   input wire logic        CFG_WR_I,
   input wire logic        CFG_RD_I,
   input wire logic [11:0] CFG_ADDR_I,
   input wire logic [3:0]  CFG_BE_I,
   input wire logic [31:0] CFG_WDATA_I,
   input wire logic [31:0] CFG_RDATA_O,
   input wire logic        CFG_HIT_O,
   input wire logic        L0S_TX_EN_O,
   input wire logic        L1_EN_O,
   input wire logic        L0S_RX_EN_O,
   input wire logic        RETRAIN_O,
   input wire logic [12:0] FTS_COUNT_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence s_ctl_wr; CFG_WR_I && CFG_ADDR_I == 12'h0d0 && CFG_BE_I[0]; endsequence
   sequence s_reg_rd; CFG_RD_I && CFG_ADDR_I == 12'h0d0; endsequence
   a_aspm_decode: assert property (s_ctl_wr |=> {L1_EN_O, L0S_TX_EN_O} == $past(CFG_WDATA_I[1:0]))
      else $error("power control outputs differ from written code");
   a_ctrl_hold: assert property (!CFG_WR_I |=> $stable(L1_EN_O) && $stable(FTS_COUNT_O))
      else $error("control output moved without a write");
   a_rx_l0s_on: assert property ($past(!SYS_RST_I) |-> L0S_RX_EN_O)
      else $error("receive L0s entry not enabled");
   a_rsvd_zero: assert property (s_reg_rd |=> (CFG_RDATA_O & 32'hc000_f12c) == 32'h0)
      else $error("reserved or fixed bit read as one");
   // The upstream port never retrains, so the pulse is only owed downstream
   a_retrain_pulse: assert property (s_ctl_wr ##0 (CFG_WDATA_I[5] && !UPSTREAM) |=> RETRAIN_O ##1 !RETRAIN_O)
      else $error("retrain pulse missing or too long");
   a_retrain_cause: assert property (RETRAIN_O |-> !UPSTREAM && $past(CFG_WR_I && CFG_WDATA_I[5] && CFG_BE_I[0] && CFG_ADDR_I == 12'h0d0))
      else $error("retrain without a write");
   a_ext_sync: assert property (s_ctl_wr |=> FTS_COUNT_O == ($past(CFG_WDATA_I[7]) ? 13'h1000 : 13'h0))
      else $error("fast training count wrong");
   a_miss_quiet: assert property ((CFG_WR_I || CFG_RD_I) && CFG_ADDR_I != 12'h0d0 |=> !CFG_HIT_O)
      else $error("hit on unmapped address");
endmodule
bind plcs_link_regs plcs_link_regs_chk #(.UPSTREAM(UPSTREAM)) u_chk (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
   .CFG_WR_I(CFG_WR_I), .CFG_RD_I(CFG_RD_I), .CFG_ADDR_I(CFG_ADDR_I), .CFG_BE_I(CFG_BE_I),
   .CFG_WDATA_I(CFG_WDATA_I), .CFG_RDATA_O(CFG_RDATA_O), .CFG_HIT_O(CFG_HIT_O),
   .L0S_TX_EN_O(L0S_TX_EN_O), .L1_EN_O(L1_EN_O), .L0S_RX_EN_O(L0S_RX_EN_O),
   .RETRAIN_O(RETRAIN_O), .FTS_COUNT_O(FTS_COUNT_O));
`default_nettype wire

// >>> plcs_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module plcs_link_model (
   input  wire logic  clk_i,
   output logic       start_o,
   output logic       fail_o,
   output logic       done_o,
   output logic [3:0] speed_o,
   output logic [5:0] width_o,
   output logic       dl_o
);
   initial begin
      {start_o, fail_o, done_o, dl_o} = 4'h0;
      speed_o = 4'h2;
      width_o = 6'h01;
   end
   // Width is not meaningful while training, so it shows a wrong value
   task start_training();
      @(posedge clk_i);
      start_o <= 1'b1;
      dl_o    <= 1'b0;
      width_o <= ~width_o;
      @(posedge clk_i);
      start_o <= 1'b0;
   endtask
   task end_training(input logic ok, input logic [3:0] spd, input logic [5:0] w);
      @(posedge clk_i);
      {fail_o, done_o, dl_o} <= {!ok, ok, ok};
      if (ok) begin
         {speed_o, width_o} <= {spd, w};
      end
      @(posedge clk_i);
      {fail_o, done_o} <= 2'h0;
   endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
   logic        clk, rst, cfg_wr, cfg_rd, strap, ldr_wr, ldr_v, hit, tx0, l1, rx0;
   logic        dis, rtr, cclk, hwd, bwm, abw, tst, tfl, tdn, dla;
   logic [11:0] addr;
   logic [3:0]  be, spd;
   logic [5:0]  wid;
   logic [31:0] wdata, rdata;
   logic [12:0] fts, ts1;
   logic        u_dis, u_rtr, u_bwm, u_abw;
   int          n_errors = 0;
   int          num_checks = 0;
   plcs_link_regs #(.UPSTREAM(1'b0)) DUT (.MCLK_I(clk), .SYS_RST_I(rst), .CFG_WR_I(cfg_wr),
      .CFG_RD_I(cfg_rd), .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata),
      .CFG_RDATA_O(rdata), .CFG_HIT_O(hit), .TRAIN_START_I(tst), .TRAIN_FAIL_I(tfl),
      .TRAIN_DONE_I(tdn), .LINK_SPEED_I(spd), .LINK_WIDTH_I(wid), .DL_ACTIVE_I(dla),
      .SLOT_CLOCK_STRAP_I(strap), .LOADER_SLOT_CLK_WR_I(ldr_wr), .LOADER_SLOT_CLK_I(ldr_v),
      .L0S_TX_EN_O(tx0), .L1_EN_O(l1), .L0S_RX_EN_O(rx0), .LINK_DISABLE_O(dis),
      .RETRAIN_O(rtr), .COMMON_CLK_O(cclk), .FTS_COUNT_O(fts), .TS1_COUNT_O(ts1),
      .HW_AUTO_WIDTH_DIS_O(hwd), .BW_MGMT_IE_O(bwm), .AUTO_BW_IE_O(abw));
   // Upstream copy shares every input so its fixed-zero bits can be compared
   plcs_link_regs #(.UPSTREAM(1'b1)) DUT_UP (.MCLK_I(clk), .SYS_RST_I(rst), .CFG_WR_I(cfg_wr),
      .CFG_RD_I(cfg_rd), .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata),
      .CFG_RDATA_O(), .CFG_HIT_O(), .TRAIN_START_I(tst), .TRAIN_FAIL_I(tfl),
      .TRAIN_DONE_I(tdn), .LINK_SPEED_I(spd), .LINK_WIDTH_I(wid), .DL_ACTIVE_I(dla),
      .SLOT_CLOCK_STRAP_I(strap), .LOADER_SLOT_CLK_WR_I(ldr_wr), .LOADER_SLOT_CLK_I(ldr_v),
      .L0S_TX_EN_O(), .L1_EN_O(), .L0S_RX_EN_O(), .LINK_DISABLE_O(u_dis),
      .RETRAIN_O(u_rtr), .COMMON_CLK_O(), .FTS_COUNT_O(), .TS1_COUNT_O(),
      .HW_AUTO_WIDTH_DIS_O(), .BW_MGMT_IE_O(u_bwm), .AUTO_BW_IE_O(u_abw));
   plcs_link_model P (.clk_i(clk), .start_o(tst), .fail_o(tfl), .done_o(tdn),
      .speed_o(spd), .width_o(wid), .dl_o(dla));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // One access per call; strobe drops at the taking edge, answer sampled just after it
   task xfer(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
             input logic [31:0] e = 32'h0, input logic [31:0] m = 32'hffff_ffff);
      {cfg_wr, cfg_rd, addr, be, wdata} <= {w, !w, a, b, d};
      @(posedge clk);
      {cfg_wr, cfg_rd} <= 2'h0;
      #1;
      if (!w) begin
         `CHK("rdata", e & m, rdata & m)
         `CHK("hit", a == 12'h0d0, hit)
      end
   endtask
   task summarize();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {rst, strap} = 2'h3;
      {cfg_wr, cfg_rd, ldr_wr, ldr_v, addr, be, wdata} = 52'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      xfer(0, 12'h0d0, 4'h0, 0, 32'h1012_0000);
      for (int i = 0; i < 4; i++) begin
         xfer(1, 12'h0d0, 4'h1, 32'(i));
         `CHK("aspm", i[1:0], {l1, tx0})
         `CHK("rx_l0s", 1'b1, rx0)
      end
      xfer(0, 12'h0d0, 4'h0, 0, 32'h1012_0003);
      xfer(1, 12'h0d0, 4'hf, 32'hffff_ffff);
      `CHK("ctl", 10'h3ff, {dis, rtr, cclk, hwd, bwm, abw, fts == 13'h1000, ts1 == 13'h0400, l1, tx0})
      `CHK("up_ctl", 4'h0, {u_dis, u_rtr, u_bwm, u_abw})
      xfer(0, 12'h0d0, 4'h0, 0, 32'h1012_0ed3);
      xfer(1, 12'h0d0, 4'h2, 0);
      xfer(0, 12'h0d0, 4'h0, 0, 32'h1012_00d3);
      xfer(1, 12'h0d0, 4'h1, 0);
      `CHK("clr", 6'h0, {dis, rtr, cclk, l1, fts != 13'h0, ts1 != 13'h0})
      xfer(1, 12'h0d4, 4'hf, 32'hffff_ffff);
      xfer(0, 12'h0d4, 4'h0, 0, 32'h0);
      xfer(0, 12'h0d0, 4'h0, 0, 32'h1012_0000);
      P.start_training();
      xfer(0, 12'h0d0, 4'h0, 0, 32'h1812_0000);
      P.end_training(1'b0, 4'h1, 6'h04);
      xfer(0, 12'h0d0, 4'h0, 0, 32'h1412_0000, 32'hf7ff_ffff);
      P.start_training();
      P.end_training(1'b1, 4'h1, 6'h04);
      xfer(0, 12'h0d0, 4'h0, 0, 32'h3041_0000);
      ldr_wr <= 1'b1;
      @(posedge clk);
      ldr_wr <= 1'b0;
      xfer(0, 12'h0d0, 4'h0, 0, 32'h2041_0000);
      summarize();
   end
endmodule
`default_nettype wire
